// *** src/ddisl_irq_latch.sv ***
// ddisl_irq_latch: status/mode registers and active-low interrupt for the
// converter event sources.
// assumes: one clock, asynchronous active-low reset, event sources arrive
// asynchronously, host reaches registers over the on-chip register port.
//
// Functional notes
// - channel-1 alignment-locked latches and interrupts in latch mode, else live.
// - mode bit 2 selects rotate latching with interrupt, else live rotate level.
// - mode bit 1 selects outside-window latching with interrupt, else live level.
// - mode bit 0 selects tripped latching with interrupt, else live level.
// - all channel-1 mode bits are read/write and reset to 0 (live).
// - calibration passed is bit 7 of status register 0x023, live or latched.
// - calibration failed is bit 6, live or latched with interrupt.
// - bit 5 reports converter multiplier lock lost, live or latched.
// - bit 4 reports converter multiplier locked, live or latched.
// - bit 3 reports link multiplier lock lost, live or latched.
// - a latched bit holds until the host writes 1 to it or clears its mode bit, then clears.
// - latch mode captures only rising edges and each capture pulls the interrupt low.
`timescale 1ns/1ns
module ddisl_irq_latch (
    // clock and reset
    input  wire logic                           ref_clk_i,
    input  wire logic                           rst_n_i,
    // register port
    input  wire ddisl_pkg::ddisl_req_s          req_i,
    output logic [ddisl_pkg::DATA_W-1:0]        rdata_o,
    output logic                                rd_ack_o,
    // event sources
    input  wire logic                           chan1_align_locked_i,
    input  wire logic                           chan1_align_rotated_i,
    input  wire logic                           chan1_outside_window_i,
    input  wire logic                           chan1_align_tripped_i,
    input  wire logic                           calibration_passed_i,
    input  wire logic                           calibration_failed_i,
    input  wire logic                           converter_pll_lost_i,
    input  wire logic                           converter_pll_locked_i,
    input  wire logic                           link_pll_lost_i,
    // interrupt
    output logic                                irq_n_o
);

    // ****************************************************************
    // address decode
    // ****************************************************************
    function automatic logic hit(input logic [ddisl_pkg::ADDR_W-1:0] a,
                                 input logic [ddisl_pkg::ADDR_W-1:0] ref_a);
        hit = (a == ref_a);
    endfunction

    wire hit_ch1_mode_w = hit(req_i.addr, ddisl_pkg::CHAN1_STATUS_MODE_SELECT_ADDR);
    wire hit_sta_a_w    = hit(req_i.addr, ddisl_pkg::IRQ_EVENT_STATUS_A_ADDR);
    wire hit_sta_mode_w = hit(req_i.addr, ddisl_pkg::STATUS_A_MODE_SELECT_ADDR);
    wire hit_ch1_sta_w  = hit(req_i.addr, ddisl_pkg::CHAN1_EVENT_STATUS_ADDR);

    // ****************************************************************
    // source synchronisation
    // ****************************************************************
    logic [ddisl_pkg::NUM_SRC-1:0] src_raw_w;
    logic [ddisl_pkg::NUM_SRC-1:0] src_sync_w;

    assign src_raw_w[ddisl_pkg::SRC_CHAN1_TRIPPED]   = chan1_align_tripped_i;
    assign src_raw_w[ddisl_pkg::SRC_CHAN1_WINDOW]    = chan1_outside_window_i;
    assign src_raw_w[ddisl_pkg::SRC_CHAN1_ROTATED]   = chan1_align_rotated_i;
    assign src_raw_w[ddisl_pkg::SRC_CHAN1_LOCKED]    = chan1_align_locked_i;
    assign src_raw_w[ddisl_pkg::SRC_LINK_PLL_LOST]   = link_pll_lost_i;
    assign src_raw_w[ddisl_pkg::SRC_CONV_PLL_LOCKED] = converter_pll_locked_i;
    assign src_raw_w[ddisl_pkg::SRC_CONV_PLL_LOST]   = converter_pll_lost_i;
    assign src_raw_w[ddisl_pkg::SRC_CAL_FAILED]      = calibration_failed_i;
    assign src_raw_w[ddisl_pkg::SRC_CAL_PASSED]      = calibration_passed_i;

    ddisl_sync #(
        .W (ddisl_pkg::NUM_SRC)
    ) u_sync (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .async_i   (src_raw_w),
        .sync_o    (src_sync_w)
    );

    // ****************************************************************
    // mode registers
    // ****************************************************************
    logic [ddisl_pkg::NUM_SRC-1:0] mode_q;
    logic [ddisl_pkg::NUM_SRC-1:0] mode_d;

    always_comb begin
        mode_d = mode_q;
        if (req_i.wr && hit_ch1_mode_w) begin
            mode_d[ddisl_pkg::CHAN1_FIELD_LSB +: ddisl_pkg::CHAN1_FIELD_W] =
                req_i.wdata[ddisl_pkg::CHAN1_FIELD_LSB +: ddisl_pkg::CHAN1_FIELD_W];
        end
        if (req_i.wr && hit_sta_mode_w) begin
            mode_d[ddisl_pkg::SRC_LINK_PLL_LOST +: ddisl_pkg::STA_A_FIELD_W] =
                req_i.wdata[ddisl_pkg::STA_A_FIELD_LSB +: ddisl_pkg::STA_A_FIELD_W];
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_q <= ddisl_pkg::MODE_RESET;
        end else begin
            mode_q <= mode_d;
        end
    end

    // ****************************************************************
    // write-one-to-clear strobes
    // ****************************************************************
    logic [ddisl_pkg::NUM_SRC-1:0] clear_w;

    assign clear_w[ddisl_pkg::CHAN1_FIELD_LSB +: ddisl_pkg::CHAN1_FIELD_W] =
        (req_i.wr && hit_ch1_sta_w) ?
        req_i.wdata[ddisl_pkg::CHAN1_FIELD_LSB +: ddisl_pkg::CHAN1_FIELD_W] : '0;
    assign clear_w[ddisl_pkg::SRC_LINK_PLL_LOST +: ddisl_pkg::STA_A_FIELD_W] =
        (req_i.wr && hit_sta_a_w) ?
        req_i.wdata[ddisl_pkg::STA_A_FIELD_LSB +: ddisl_pkg::STA_A_FIELD_W] : '0;

    // ****************************************************************
    // status cells
    // ****************************************************************
    logic [ddisl_pkg::NUM_SRC-1:0] status_w;
    logic [ddisl_pkg::NUM_SRC-1:0] latched_w;

    // one cell per source, live or latched
    genvar gi;
    generate
        for (gi = 0; gi < ddisl_pkg::NUM_SRC; gi++) begin : g_cell
            ddisl_status_cell u_cell (
                .ref_clk_i    (ref_clk_i),
                .rst_n_i      (rst_n_i),
                .src_i        (src_sync_w[gi]),
                .latch_mode_i (mode_q[gi]),
                .clear_i      (clear_w[gi]),
                .status_o     (status_w[gi]),
                .latched_o    (latched_w[gi])
            );
        end
    endgenerate

    // ****************************************************************
    // read data
    // ****************************************************************
    wire [ddisl_pkg::DATA_W-1:0] ch1_mode_rd_w =
        ddisl_pkg::DATA_W'({mode_q[ddisl_pkg::CHAN1_FIELD_LSB +: ddisl_pkg::CHAN1_FIELD_W]});
    wire [ddisl_pkg::DATA_W-1:0] sta_mode_rd_w =
        {mode_q[ddisl_pkg::SRC_LINK_PLL_LOST +: ddisl_pkg::STA_A_FIELD_W],
         3'b000};
    wire [ddisl_pkg::DATA_W-1:0] ch1_sta_rd_w =
        ddisl_pkg::DATA_W'({status_w[ddisl_pkg::CHAN1_FIELD_LSB +: ddisl_pkg::CHAN1_FIELD_W]});
    wire [ddisl_pkg::DATA_W-1:0] sta_a_rd_w =
        {status_w[ddisl_pkg::SRC_LINK_PLL_LOST +: ddisl_pkg::STA_A_FIELD_W],
         3'b000};

    wire [ddisl_pkg::DATA_W-1:0] rdata_w =
        hit_ch1_mode_w ? ch1_mode_rd_w :
        hit_sta_a_w    ? sta_a_rd_w    :
        hit_sta_mode_w ? sta_mode_rd_w :
        hit_ch1_sta_w  ? ch1_sta_rd_w  : ddisl_pkg::RDATA_UNMAPPED;

    // ****************************************************************
    // output registers
    // ****************************************************************
    logic [ddisl_pkg::DATA_W-1:0] rdata_q;
    logic                         rd_ack_q;
    logic                         irq_n_q;
    wire                          irq_n_d = ~(|latched_w);

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_q  <= ddisl_pkg::RDATA_RESET;
            rd_ack_q <= 1'b0;
            irq_n_q  <= 1'b1;
        end else begin
            rdata_q  <= req_i.rd ? rdata_w : rdata_q;
            rd_ack_q <= req_i.rd;
            irq_n_q  <= irq_n_d;
        end
    end

    assign rdata_o  = rdata_q;
    assign rd_ack_o = rd_ack_q;
    assign irq_n_o  = irq_n_q;

endmodule // ddisl_irq_latch

// *** src/ddisl_pkg.sv ***
// ddisl_pkg: constants and types for the interrupt status latch block.
// assumes: a single 50 MHz clock domain and a simple on-chip register port.
package ddisl_pkg;

    // ****************************************************************
    // register port geometry
    // ****************************************************************
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;

    // ****************************************************************
    // register offsets
    // ****************************************************************
    localparam logic [ADDR_W-1:0] CHAN1_STATUS_MODE_SELECT_ADDR = 12'h0022;
    localparam logic [ADDR_W-1:0] IRQ_EVENT_STATUS_A_ADDR       = 12'h0023;
    localparam logic [ADDR_W-1:0] STATUS_A_MODE_SELECT_ADDR     = 12'h00F0;
    localparam logic [ADDR_W-1:0] CHAN1_EVENT_STATUS_ADDR       = 12'h00F1;

    // ****************************************************************
    // source index layout (one vector of all event sources)
    // ****************************************************************
    localparam int NUM_SRC               = 9;
    localparam int SRC_CHAN1_TRIPPED     = 0;
    localparam int SRC_CHAN1_WINDOW      = 1;
    localparam int SRC_CHAN1_ROTATED     = 2;
    localparam int SRC_CHAN1_LOCKED      = 3;
    localparam int SRC_LINK_PLL_LOST     = 4;
    localparam int SRC_CONV_PLL_LOCKED   = 5;
    localparam int SRC_CONV_PLL_LOST     = 6;
    localparam int SRC_CAL_FAILED        = 7;
    localparam int SRC_CAL_PASSED        = 8;

    // ****************************************************************
    // field positions inside the registers
    // ****************************************************************
    localparam int CHAN1_FIELD_LSB  = 0;
    localparam int CHAN1_FIELD_W    = 4;
    localparam int STA_A_FIELD_LSB  = 3;
    localparam int STA_A_FIELD_W    = 5;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [NUM_SRC-1:0] MODE_RESET     = 9'h000;
    localparam logic [DATA_W-1:0]  RDATA_RESET    = 8'h00;
    localparam logic [DATA_W-1:0]  RDATA_UNMAPPED = 8'h00;

    // ****************************************************************
    // register port request carrier
    // ****************************************************************
    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } ddisl_req_s;

endpackage

// *** src/ddisl_sync.sv ***
// ddisl_sync: two-flop synchroniser for asynchronous event sources.
// assumes: the first stage is read by the second stage only.
`timescale 1ns/1ns
module ddisl_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         ref_clk_i,
    input  wire logic         rst_n_i,
    // data
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);

    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;

endmodule // ddisl_sync

// *** src/ddisl_status_cell.sv ***
// ddisl_status_cell: one status bit, live or rising-edge latched.
// assumes: src_i is already synchronised to ref_clk_i.
`timescale 1ns/1ns
module ddisl_status_cell (
    // clock and reset
    input  wire logic ref_clk_i,
    input  wire logic rst_n_i,
    // control
    input  wire logic src_i,
    input  wire logic latch_mode_i,
    input  wire logic clear_i,
    // result
    output logic      status_o,
    output logic      latched_o
);

    logic src_prev_q;
    logic latched_q;
    logic latched_d;
    wire  rise_w;

    assign rise_w = src_i & ~src_prev_q;

    // set wins over a same-cycle clear; live mode holds nothing
    always_comb begin
        latched_d = latched_q;
        if (!latch_mode_i) begin
            latched_d = 1'b0;
        end else if (rise_w) begin
            latched_d = 1'b1;
        end else if (clear_i) begin
            latched_d = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            src_prev_q <= 1'b0;
            latched_q  <= 1'b0;
        end else begin
            src_prev_q <= src_i;
            latched_q  <= latched_d;
        end
    end

    // live level in live mode, held capture in latch mode
    assign status_o  = latch_mode_i ? latched_q : src_i;
    assign latched_o = latched_q;

endmodule // ddisl_status_cell

// *** sim/ddisl_irq_latch_chk.sv ***
// ddisl_irq_latch_chk: port assertions for the interrupt status latch.
// assumes: bound into ddisl_irq_latch; one clock, async active-low reset.
`timescale 1ns/1ns
module ddisl_irq_latch_chk (
    // clock and reset
    input wire logic                         ref_clk_i,
    input wire logic                         rst_n_i,
    // register port
    input wire ddisl_pkg::ddisl_req_s        req_i,
    input wire logic [ddisl_pkg::DATA_W-1:0] rdata_o,
    input wire logic                         rd_ack_o,
    // event sources
    input wire logic                         chan1_align_locked_i,
    input wire logic                         chan1_align_rotated_i,
    input wire logic                         chan1_outside_window_i,
    input wire logic                         chan1_align_tripped_i,
    input wire logic                         calibration_passed_i,
    input wire logic                         calibration_failed_i,
    input wire logic                         converter_pll_lost_i,
    input wire logic                         converter_pll_locked_i,
    input wire logic                         link_pll_lost_i,
    // interrupt
    input wire logic                         irq_n_o
);
    wire [8:0] src_w = {calibration_passed_i, calibration_failed_i, converter_pll_lost_i,
        converter_pll_locked_i, link_pll_lost_i, chan1_align_locked_i,
        chan1_align_rotated_i, chan1_outside_window_i, chan1_align_tripped_i};
    wire       unmap_w = !(req_i.addr inside {12'h022, 12'h023, 12'h0F0, 12'h0F1});

    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    // some source rose through the two sync stages and the edge detector
    sequence s_src_rose;
        (|($past(src_w, 4) & ~$past(src_w, 5))) || (|($past(src_w, 5) & ~$past(src_w, 6)));
    endsequence

    AST_RD_ACK: assert property (req_i.rd |=> rd_ack_o)
        else $error("read not acknowledged");
    AST_NO_ACK: assert property (!req_i.rd |=> !rd_ack_o)
        else $error("acknowledge without read");
    AST_UNMAP: assert property (req_i.rd && unmap_w |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    AST_MODE_RESV: assert property (req_i.rd && req_i.addr == 12'h022 |=> rdata_o[7:4] == 4'h0)
        else $error("reserved mode bits not zero");
    AST_RST: assert property ($rose(rst_n_i) |-> irq_n_o && !rd_ack_o)
        else $error("outputs not idle after reset");
    AST_IRQ_FALL: assert property ($fell(irq_n_o) |-> s_src_rose)
        else $error("interrupt without a rising source");
    // a clear releases two edges after the write, leaving latch mode three edges after it
    AST_IRQ_RISE: assert property ($rose(irq_n_o) |-> $past(req_i.wr, 2) || $past(req_i.wr, 3))
        else $error("interrupt released without a write");
    AST_RDATA_HOLD: assert property (!rd_ack_o |-> $stable(rdata_o))
        else $error("read data moved without a read");
endmodule // ddisl_irq_latch_chk

bind ddisl_irq_latch ddisl_irq_latch_chk u_chk (.ref_clk_i, .rst_n_i, .req_i, .rdata_o,
    .rd_ack_o, .chan1_align_locked_i, .chan1_align_rotated_i, .chan1_outside_window_i,
    .chan1_align_tripped_i, .calibration_passed_i, .calibration_failed_i,
    .converter_pll_lost_i, .converter_pll_locked_i, .link_pll_lost_i, .irq_n_o);

// *** sim/ddisl_host_model.sv ***
// ddisl_host_model: host processor on the register port.
// assumes: one-cycle strobes driven 1 ns after the rising edge.
`timescale 1ns/1ns
module ddisl_host_model (
    // clock
    input  wire logic                         ref_clk_i,
    // register port
    output ddisl_pkg::ddisl_req_s             req_o,
    input  wire logic [ddisl_pkg::DATA_W-1:0] rdata_i,
    input  wire logic                         rd_ack_i
);
    initial req_o = '0;

    // idle address and data show the inverse of the last request
    task automatic put(input logic w, input logic [11:0] a, input logic [7:0] v);
        @(posedge ref_clk_i);
        #1 req_o = '{w, !w, a, v};
        @(posedge ref_clk_i);
        #1 req_o = '{1'b0, 1'b0, ~a, ~v};
    endtask

    // writing ones to latched bits is how the host acknowledges events
    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        put(1'b1, a, v);
    endtask

    task automatic rd(input logic [11:0] a, output logic [7:0] v);
        int i;
        put(1'b0, a, 8'h00);
        for (i = 0; i < 4 && !rd_ack_i; i++) begin
            @(posedge ref_clk_i);
            #1;
        end
        v = rd_ack_i ? rdata_i : 8'hxx;
    endtask
endmodule // ddisl_host_model

// *** sim/dual_dac_irq_status_latch_test.sv ***
// dual_dac_irq_status_latch_test: self-checking bench for ddisl_irq_latch.
// assumes: the host model owns the register port; the bench drives event pins.
`timescale 1ns/1ns
module dual_dac_irq_status_latch_test;
    logic                  ref_clk;
    logic                  rst_n;
    logic [8:0]            src;
    ddisl_pkg::ddisl_req_s req;
    logic [7:0]            rdata;
    logic                  rd_ack;
    logic                  irq_n;
    logic [7:0]            d;
    int                    n_errors;
    int                    num_checks;

    ddisl_irq_latch dut (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .req_i(req), .rdata_o(rdata),
        .rd_ack_o(rd_ack), .chan1_align_tripped_i(src[0]), .chan1_outside_window_i(src[1]),
        .chan1_align_rotated_i(src[2]), .chan1_align_locked_i(src[3]),
        .link_pll_lost_i(src[4]), .converter_pll_locked_i(src[5]),
        .converter_pll_lost_i(src[6]), .calibration_failed_i(src[7]),
        .calibration_passed_i(src[8]), .irq_n_o(irq_n));
    ddisl_host_model host (.ref_clk_i(ref_clk), .req_o(req), .rdata_i(rdata), .rd_ack_i(rd_ack));

    initial ref_clk = 1'b0;
    always #10 ref_clk = ~ref_clk;

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    function automatic logic [11:0] mode_a(input int i);
        return i < 4 ? 12'h022 : 12'h0F0;
    endfunction
    function automatic logic [11:0] sta_a(input int i);
        return i < 4 ? 12'h0F1 : 12'h023;
    endfunction
    function automatic logic [7:0] bit_of(input int i);
        return 8'h01 << (i < 4 ? i : i - 1);
    endfunction

    task automatic t_reset;
        logic [11:0] a [4] = '{12'h022, 12'h023, 12'h0F0, 12'h0F1};
        chk("irq_n", 8'h01, 8'(irq_n));
        foreach (a[k]) begin
            host.rd(a[k], d);
            chk("reset", 8'h00, d);
        end
    endtask
    task automatic t_mode_rw;
        host.wr(12'h022, 8'hFF);
        host.rd(12'h022, d);
        chk("mode1", 8'h0F, d);
        host.wr(12'h0F0, 8'hFF);
        host.rd(12'h0F0, d);
        chk("mode_a", 8'hF8, d);
        host.rd(12'h555, d);
        chk("unmapped", 8'h00, d);
        host.wr(12'h022, 8'h00);
        host.wr(12'h0F0, 8'h00);
        host.rd(12'h022, d);
        chk("mode_clr", 8'h00, d);
    endtask
    task automatic t_live;
        for (int i = 0; i < 9; i++) begin
            src[i] = 1'b1;
            cyc(4);
            host.rd(sta_a(i), d);
            chk("live_hi", bit_of(i), d);
            chk("live_irq", 8'h01, 8'(irq_n));
            src[i] = 1'b0;
            cyc(4);
            host.rd(sta_a(i), d);
            chk("live_lo", 8'h00, d);
        end
    endtask
    task automatic t_latch;
        for (int i = 0; i < 9; i++) begin
            host.wr(mode_a(i), bit_of(i));
            src[i] = 1'b1;
            cyc(6);
            chk("latch_irq", 8'h00, 8'(irq_n));
            src[i] = 1'b0;
            host.wr(sta_a(i), ~bit_of(i));
            cyc(4);
            host.rd(sta_a(i), d);
            chk("latch_hold", bit_of(i), d);
            host.wr(sta_a(i), bit_of(i));
            cyc(3);
            chk("clr_irq", 8'h01, 8'(irq_n));
            host.rd(sta_a(i), d);
            chk("clr_sta", 8'h00, d);
            host.wr(mode_a(i), 8'h00);
        end
    endtask
    task automatic t_two;
        host.wr(12'h0F0, 8'h18);
        src[5:4] = 2'b11;
        cyc(6);
        host.wr(12'h023, 8'h08);
        cyc(3);
        chk("one_left", 8'h00, 8'(irq_n));
        host.wr(12'h023, 8'h10);
        cyc(3);
        chk("none_left", 8'h01, 8'(irq_n));
        host.rd(12'h023, d);
        chk("no_relatch", 8'h00, d);
        src[5:4] = 2'b00;
        host.wr(12'h0F0, 8'h00);
        host.wr(12'h0F0, 8'h80);
        src[8] = 1'b1;
        cyc(6);
        chk("pass_irq", 8'h00, 8'(irq_n));
        host.wr(12'h0F0, 8'h00);
        cyc(3);
        chk("live_drop", 8'h01, 8'(irq_n));
        host.wr(12'h0F0, 8'h80);
        cyc(3);
        chk("high_no_latch", 8'h01, 8'(irq_n));
        host.rd(12'h023, d);
        chk("high_no_sta", 8'h00, d);
        src[8] = 1'b0;
        host.wr(12'h0F0, 8'h00);
    endtask

    task automatic test_done;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        n_errors = 0;
        num_checks = 0;
        rst_n = 1'b0;
        src = '0;
        repeat (5) @(posedge ref_clk);
        #1 rst_n = 1'b1;
        t_reset();
        t_mode_rw();
        t_live();
        t_latch();
        t_two();
        test_done();
    end

    // about 400 cycles are needed; give over twelve times that
    initial begin
        #100000;
        n_errors++;
        test_done();
    end
endmodule // dual_dac_irq_status_latch_test
